// ---- verilog/pair_combiner.sv ----
// Purpose: odd/even channel pair output stage with APB registers
// Assumes: pattern inputs synchronous to clk; sub-cycle offset sent to analog vernier
// Notes: whole-cycle offset handled here, fine part leaves on offset_fine
//
// Behaviour
// R1 - with offset on, even output is odd pattern inverted and shifted
// R2 - offset shift accepted only within minus one to plus one nanosecond
// R3 - positive shift delays inverted output, negative shift advances it
// R4 - shift quantised to 1 ps or 0.2 ps step by rate variant
// R5 - offset disallowed on channels mapped to single-channel modules
// R6 - offset enable refused when channel already mapped to even channel
// R7 - even mapping refused while offset enabled
// R8 - odd mapping with offset on releases the even mapping
// R9 - offset works in pulse mode as in data mode
// R10 - odd combiner: pass-through or XOR with even signal
// R11 - even combiner: pass-through or AND with odd signal
// R12 - combiner inputs taken after each channel's delay
// R13 - polarity inversion placed after the combiner
// R14 - inverted: data 0 drives high, data 1 drives low
// R15 - combiner forced to pass-through on single-channel modules
// R16 - unmapped channel takes any setting; mapped limited by position
// R17 - combiner works in pulse mode too
// R18 - jitter span selectable one or two nanoseconds
// R19 - jitter range only acts on the jitter-capable module
// R20 - one unstable cycle allowed after jitter range change
// R21 - offset off: even channel outputs its own pattern path
`timescale 1ns/1ps
module pair_combiner
    import pair_combiner_pkg::*;
#(
    parameter int DEPTH = DELAY_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // patterns
    input wire logic pat_odd,
    input wire logic pat_even,
    // outputs
    output logic out_odd,
    output logic out_even,
    output logic signed [OFFSET_W-1:0] offset_fine,
    output logic jitter_2ns,
    output logic jitter_unstable
);
    logic [7:0] ctrl_ff;
    logic [3:0] map_ff;
    logic signed [OFFSET_W-1:0] offset_ff;
    logic [DELAY_W-1:0] dly_odd_ff;
    logic [DELAY_W-1:0] dly_even_ff;
    logic err_range_ff;
    logic err_ref_ff;
    logic jit_cnt_ff;
    logic wr_en;
    logic signed [OFFSET_W-1:0] wr_ofs;
    logic ofs_ok;
    logic step_ok;
    logic en_req_ok;
    logic [DELAY_W-1:0] tap_inv;
    logic [DELAY_W-1:0] base_tap;
    logic [DELAY_W-1:0] ofs_cycles;
    logic ofs_neg;
    logic d_odd;
    logic d_even;
    logic d_inv;
    logic comb_odd;
    logic comb_even;
    logic ofs_on;
    logic add_odd_on;
    logic add_even_on;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign wr_ofs = pwdata[OFFSET_W-1:0];
    // range window in tenths of a ps
    assign ofs_ok = (int'(wr_ofs) >= OFFSET_MIN_DPS) && (int'(wr_ofs) <= OFFSET_MAX_DPS); // R2
    // step granularity by variant
    assign step_ok = ctrl_ff[BIT_HIGH_RATE] ? ((int'(wr_ofs) % STEP_HIGH_RATE_DPS) == 0)
                                            : ((int'(wr_ofs) % STEP_LOW_RATE_DPS) == 0); // R4
    // enable refused on single module or even mapping
    assign en_req_ok = !map_ff[BIT_SINGLE_MOD] && !map_ff[BIT_MAP_EVEN]; // R5 R6

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable && pwrite) begin
            if (paddr == OFS_OFFSET) begin
                pslverr = !(ofs_ok && step_ok);
            end else if (paddr == OFS_PAIR_CTRL) begin
                pslverr = pwdata[BIT_OFFSET_EN] && !en_req_ok;
            end else if (paddr == OFS_MAP) begin
                pslverr = pwdata[BIT_MAP_EVEN] && ctrl_ff[BIT_OFFSET_EN];
            end
        end
    end

    // control register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= RESET_WORD[7:0];
        end else if (wr_en && paddr == OFS_PAIR_CTRL) begin
            ctrl_ff <= pwdata[7:0];
            if (pwdata[BIT_OFFSET_EN] && !en_req_ok) begin
                ctrl_ff[BIT_OFFSET_EN] <= ctrl_ff[BIT_OFFSET_EN]; // R5 R6
            end
            // mapped odd only odd options, mapped even only even options
            if (map_ff[BIT_MAP_EVEN] || map_ff[BIT_SINGLE_MOD]) begin
                ctrl_ff[BIT_ADD_ODD] <= 1'b0; // R16 R15
            end
            if (map_ff[BIT_MAP_ODD] || map_ff[BIT_SINGLE_MOD]) begin
                ctrl_ff[BIT_ADD_EVEN] <= 1'b0; // R16 R15
            end
        end else if (wr_en && paddr == OFS_MAP && pwdata[BIT_SINGLE_MOD]) begin
            ctrl_ff[BIT_OFFSET_EN] <= 1'b0; // R5
            ctrl_ff[BIT_ADD_ODD] <= 1'b0; // R15
            ctrl_ff[BIT_ADD_EVEN] <= 1'b0; // R15
        end
    end

    // mapping register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            map_ff <= RESET_WORD[3:0];
        end else if (wr_en && paddr == OFS_MAP) begin
            map_ff <= pwdata[3:0];
            if (pwdata[BIT_MAP_EVEN] && ctrl_ff[BIT_OFFSET_EN]) begin
                map_ff <= map_ff; // R7
            end else if (pwdata[BIT_MAP_ODD] && ctrl_ff[BIT_OFFSET_EN]) begin
                map_ff[BIT_MAP_EVEN] <= 1'b0; // R8
            end
        end
    end

    // offset and delays
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            offset_ff <= '0;
            dly_odd_ff <= '0;
            dly_even_ff <= '0;
        end else if (wr_en) begin
            if (paddr == OFS_OFFSET && ofs_ok && step_ok) begin
                offset_ff <= wr_ofs; // R2 R4
            end
            if (paddr == OFS_DELAY_ODD) begin
                dly_odd_ff <= pwdata[DELAY_W-1:0];
            end
            if (paddr == OFS_DELAY_EVEN) begin
                dly_even_ff <= pwdata[DELAY_W-1:0];
            end
        end
    end

    // error flags, set wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            err_range_ff <= 1'b0;
            err_ref_ff <= 1'b0;
        end else begin
            if (wr_en && paddr == OFS_OFFSET && !(ofs_ok && step_ok)) begin
                err_range_ff <= 1'b1;
            end else if (wr_en && paddr == OFS_STATUS && pwdata[BIT_ERR_RANGE]) begin
                err_range_ff <= 1'b0;
            end
            if (wr_en && pslverr && paddr != OFS_OFFSET) begin
                err_ref_ff <= 1'b1;
            end else if (wr_en && paddr == OFS_STATUS && pwdata[BIT_ERR_REFUSED]) begin
                err_ref_ff <= 1'b0;
            end
        end
    end

    // jitter range change marker
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            jit_cnt_ff <= 1'b0;
        end else begin
            jit_cnt_ff <= wr_en && paddr == OFS_PAIR_CTRL && map_ff[BIT_JITTER_MOD] &&
                          (pwdata[BIT_JIT_2NS] != ctrl_ff[BIT_JIT_2NS]); // R20
        end
    end

    assign jitter_2ns = map_ff[BIT_JITTER_MOD] && ctrl_ff[BIT_JIT_2NS]; // R18 R19
    assign jitter_unstable = jit_cnt_ff; // R20

    // read mux
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_PAIR_CTRL: prdata <= {24'h000000, ctrl_ff};
                OFS_OFFSET: prdata <= {{(32-OFFSET_W){offset_ff[OFFSET_W-1]}}, offset_ff};
                OFS_MAP: prdata <= {28'h0000000, map_ff};
                OFS_STATUS: prdata <= {29'h0, jit_cnt_ff, err_ref_ff, err_range_ff};
                OFS_DELAY_ODD: prdata <= {28'h0000000, dly_odd_ff};
                OFS_DELAY_EVEN: prdata <= {28'h0000000, dly_even_ff};
                default: prdata <= UNMAPPED_WORD;
            endcase
        end
    end

    // whole-cycle part of the shift around the odd delay
    assign ofs_neg = offset_ff[OFFSET_W-1];
    always_comb begin
        int mag;
        mag = ofs_neg ? -int'(offset_ff) : int'(offset_ff);
        ofs_cycles = DELAY_W'(mag / CYCLE_DPS);
    end
    assign base_tap = dly_odd_ff;
    // positive delays the inverted copy, negative advances it
    assign tap_inv = ofs_neg ? ((base_tap > ofs_cycles) ? base_tap - ofs_cycles : '0)
                             : base_tap + ofs_cycles; // R3
    assign offset_fine = ofs_on ? offset_ff : '0; // R3 R4

    assign ofs_on = ctrl_ff[BIT_OFFSET_EN] && !map_ff[BIT_SINGLE_MOD]; // R5 R9
    assign add_odd_on = ctrl_ff[BIT_ADD_ODD] && !map_ff[BIT_SINGLE_MOD]; // R15 R17
    assign add_even_on = ctrl_ff[BIT_ADD_EVEN] && !map_ff[BIT_SINGLE_MOD]; // R15 R17

    // delayed channel signals
    delay_line #(.DEPTH(DEPTH), .AW(DELAY_W)) u_dly_odd (
        .clk(clk), .rst_b(rst_b), .din(pat_odd), .tap(dly_odd_ff), .dout(d_odd)
    ); // R12
    delay_line #(.DEPTH(DEPTH), .AW(DELAY_W)) u_dly_even (
        .clk(clk), .rst_b(rst_b), .din(pat_even), .tap(dly_even_ff), .dout(d_even)
    ); // R12 R21
    delay_line #(.DEPTH(DEPTH), .AW(DELAY_W)) u_dly_inv (
        .clk(clk), .rst_b(rst_b), .din(pat_odd), .tap(tap_inv), .dout(d_inv)
    ); // R1

    assign comb_odd = add_odd_on ? (d_odd ^ d_even) : d_odd; // R10
    assign comb_even = add_even_on ? (d_even & d_odd) : d_even; // R11

    // polarity after combiner; high level is 1
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_odd <= 1'b0;
            out_even <= 1'b0;
        end else begin
            out_odd <= comb_odd ^ ctrl_ff[BIT_INV_ODD]; // R13 R14
            if (ofs_on) begin
                out_even <= ~d_inv; // R1
            end else begin
                out_even <= comb_even ^ ctrl_ff[BIT_INV_EVEN]; // R13 R14 R21
            end
        end
    end

    // checks on the registers and the output stage
    a_offset_window: assert property (@(posedge clk) disable iff (!rst_b) // R2
        (int'(offset_ff) >= OFFSET_MIN_DPS) && (int'(offset_ff) <= OFFSET_MAX_DPS))
        else $error("offset out of window");
    a_even_refused: assert property (@(posedge clk) disable iff (!rst_b) // R7
        ctrl_ff[BIT_OFFSET_EN]
        |-> !map_ff[BIT_MAP_EVEN])
        else $error("even mapped with offset on");
    a_single_no_ofs: assert property (@(posedge clk) disable iff (!rst_b) // R15
        map_ff[BIT_SINGLE_MOD]
        |-> !ofs_on && !add_odd_on && !add_even_on)
        else $error("single module not pass-through");
    a_single_ctrl: assert property (@(posedge clk) disable iff (!rst_b) // R5 R15
        map_ff[BIT_SINGLE_MOD]
        |-> !ctrl_ff[BIT_OFFSET_EN] && !ctrl_ff[BIT_ADD_ODD] && !ctrl_ff[BIT_ADD_EVEN])
        else $error("single module holds pair settings");
    a_odd_comb: assert property (@(posedge clk) disable iff (!rst_b) // R10
        1'b1
        |=> out_odd == ($past(comb_odd) ^ $past(ctrl_ff[BIT_INV_ODD])))
        else $error("odd output wrong");
    a_odd_xor: assert property (@(posedge clk) disable iff (!rst_b) // R10 R13
        add_odd_on
        |=> out_odd == (($past(d_odd) ^ $past(d_even)) ^ $past(ctrl_ff[BIT_INV_ODD])))
        else $error("odd xor wrong");
    a_even_inv: assert property (@(posedge clk) disable iff (!rst_b) // R1
        ofs_on
        |=> out_even == !$past(d_inv))
        else $error("even not inverted copy");
    a_even_and: assert property (@(posedge clk) disable iff (!rst_b) // R11
        !ofs_on && add_even_on
        |=> out_even == (($past(d_even) & $past(d_odd)) ^ $past(ctrl_ff[BIT_INV_EVEN])))
        else $error("even and wrong");
    a_even_own: assert property (@(posedge clk) disable iff (!rst_b) // R14 R21
        !ofs_on && !add_even_on
        |=> out_even == ($past(d_even) ^ $past(ctrl_ff[BIT_INV_EVEN])))
        else $error("even own path wrong");
    a_fine_off: assert property (@(posedge clk) disable iff (!rst_b) // R3
        !ofs_on |-> offset_fine == '0)
        else $error("fine offset leaked");
    a_jitter_gate: assert property (@(posedge clk) disable iff (!rst_b) // R19
        !map_ff[BIT_JITTER_MOD]
        |-> !jitter_2ns)
        else $error("jitter range leaked");
    a_jit_quiet: assert property (@(posedge clk) disable iff (!rst_b) // R19 R20
        !map_ff[BIT_JITTER_MOD]
        |=> !jitter_unstable)
        else $error("unstable flag without jitter module");
    a_jit_pulse: assert property (@(posedge clk) disable iff (!rst_b) // R20
        jitter_unstable
        |=> !jitter_unstable)
        else $error("unstable flag longer than one cycle");
    a_ofs_refuse: assert property (@(posedge clk) disable iff (!rst_b) // R2
        wr_en && paddr == OFS_OFFSET && !ofs_ok
        |=> offset_ff == $past(offset_ff))
        else $error("bad offset stored");
    a_step_refuse: assert property (@(posedge clk) disable iff (!rst_b) // R4
        wr_en && paddr == OFS_OFFSET && !step_ok
        |=> offset_ff == $past(offset_ff))
        else $error("off-step offset stored");
    a_ofs_stored: assert property (@(posedge clk) disable iff (!rst_b) // R2 R4
        wr_en && paddr == OFS_OFFSET && ofs_ok && step_ok
        |=> offset_ff == $past(wr_ofs))
        else $error("legal offset not stored");
    a_range_flag: assert property (@(posedge clk) disable iff (!rst_b) // R2
        wr_en && paddr == OFS_OFFSET && !(ofs_ok && step_ok)
        |=> err_range_ff)
        else $error("range error not flagged");
    a_enable_refused: assert property (@(posedge clk) disable iff (!rst_b) // R5 R6
        wr_en && paddr == OFS_PAIR_CTRL && pwdata[BIT_OFFSET_EN] && !en_req_ok
        |=> !ctrl_ff[BIT_OFFSET_EN])
        else $error("refused offset enable taken");
    a_map_refused: assert property (@(posedge clk) disable iff (!rst_b) // R7
        wr_en && paddr == OFS_MAP && pwdata[BIT_MAP_EVEN] && ctrl_ff[BIT_OFFSET_EN]
        |=> map_ff == $past(map_ff))
        else $error("refused mapping taken");
    a_odd_release: assert property (@(posedge clk) disable iff (!rst_b) // R8
        wr_en && paddr == OFS_MAP && pwdata[BIT_MAP_ODD] && ctrl_ff[BIT_OFFSET_EN]
        |=> !map_ff[BIT_MAP_EVEN])
        else $error("even mapping kept");
    a_odd_limit: assert property (@(posedge clk) disable iff (!rst_b) // R16
        wr_en && paddr == OFS_PAIR_CTRL && map_ff[BIT_MAP_ODD]
        |=> !ctrl_ff[BIT_ADD_EVEN])
        else $error("and setting on odd position");
    a_even_limit: assert property (@(posedge clk) disable iff (!rst_b) // R16
        wr_en && paddr == OFS_PAIR_CTRL && map_ff[BIT_MAP_EVEN]
        |=> !ctrl_ff[BIT_ADD_ODD])
        else $error("xor setting on even position");
    c_ofs_on: cover property (@(posedge clk) disable iff (!rst_b) ofs_on && d_inv);
    c_xor: cover property (@(posedge clk) disable iff (!rst_b) add_odd_on && d_even);
    c_and: cover property (@(posedge clk) disable iff (!rst_b) add_even_on && d_odd && d_even);
    c_refused: cover property (@(posedge clk) disable iff (!rst_b) wr_en && pslverr);
    c_jit: cover property (@(posedge clk) disable iff (!rst_b) jitter_unstable);
endmodule

// ---- verilog/pair_combiner_pkg.sv ----
// Purpose: shared constants for the channel pair output combiner
// Assumes: 250 MHz pattern clock, APB register access
// Notes: offsets are byte addresses of 32-bit words
package pair_combiner_pkg;
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // register byte offsets
    localparam logic [7:0] OFS_PAIR_CTRL = 8'h00;
    localparam logic [7:0] OFS_OFFSET = 8'h04;
    localparam logic [7:0] OFS_MAP = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_DELAY_ODD = 8'h10;
    localparam logic [7:0] OFS_DELAY_EVEN = 8'h14;
    // offset window in picoseconds, signed
    localparam int OFFSET_MIN_PS = -1000;
    localparam int OFFSET_MAX_PS = 1000;
    // step size in tenths of a picosecond
    localparam int STEP_LOW_RATE_DPS = 10;
    localparam int STEP_HIGH_RATE_DPS = 2;
    // offset held in tenths of a picosecond, signed
    localparam int OFFSET_W = 16;
    localparam int OFFSET_MIN_DPS = OFFSET_MIN_PS * 10;
    localparam int OFFSET_MAX_DPS = OFFSET_MAX_PS * 10;
    // delay line depth in clock cycles
    localparam int DELAY_DEPTH = 16;
    localparam int DELAY_W = 4;
    // whole-cycle part of the offset, in tenths of a ps per cycle
    localparam int CYCLE_DPS = CLK_PERIOD_PS * 10;
    // jitter settle time in cycles
    localparam int JITTER_SETTLE_CYC = 1;
    // control bit positions
    localparam int BIT_OFFSET_EN = 0;
    localparam int BIT_ADD_ODD = 1;
    localparam int BIT_ADD_EVEN = 2;
    localparam int BIT_INV_ODD = 3;
    localparam int BIT_INV_EVEN = 4;
    localparam int BIT_JIT_2NS = 5;
    localparam int BIT_HIGH_RATE = 6;
    localparam int BIT_PULSE_MODE = 7;
    // map register bit positions
    localparam int BIT_MAP_ODD = 0;
    localparam int BIT_MAP_EVEN = 1;
    localparam int BIT_SINGLE_MOD = 2;
    localparam int BIT_JITTER_MOD = 3;
    // status bit positions
    localparam int BIT_ERR_RANGE = 0;
    localparam int BIT_ERR_REFUSED = 1;
    localparam int BIT_JIT_UNSTABLE = 2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_WORD = 32'h0000_0000;
endpackage

// ---- verilog/delay_line.sv ----
// Purpose: per-bit delay line with registered tap output
// Assumes: depth is a power of two
// Notes: tap 0 is two register stages
`timescale 1ns/1ps
module delay_line #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // data
    input wire logic din,
    input wire logic [AW-1:0] tap,
    output logic dout
);
    logic [DEPTH-1:0] shift_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_ff <= '0;
        end else begin
            shift_ff <= {shift_ff[DEPTH-2:0], din};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dout <= 1'b0;
        end else begin
            dout <= shift_ff[tap];
        end
    end
endmodule

// ---- test/pattern_receiver.sv ----
// Purpose: receiving side model for the paired channel outputs
// Assumes: outputs are one level per clock cycle
// Notes: counts level changes seen on each line
`timescale 1ns/1ps
module pattern_receiver (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // received levels
    input wire logic out_odd,
    input wire logic out_even,
    // level change counts
    output int edges_odd,
    output int edges_even
);
    logic last_odd_ff;
    logic last_even_ff;

    // both lines sampled on the same edge so counts compare directly
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_odd_ff <= 1'b0;
            last_even_ff <= 1'b0;
            edges_odd <= 0;
            edges_even <= 0;
        end else begin
            last_odd_ff <= out_odd;
            last_even_ff <= out_even;
            edges_odd <= edges_odd + int'(out_odd !== last_odd_ff);
            edges_even <= edges_even + int'(out_even !== last_even_ff);
        end
    end
endmodule

// ---- test/tb.sv ----
// Purpose: self-checking bench for the channel pair combiner
// Assumes: zero-wait apb slave, output lags pattern by tap plus three
// Notes: table rows for data paths, hand tests for refusals and reset
`timescale 1ns/1ps
module tb;
    import pair_combiner_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] map;
        logic [31:0] ofs;
        logic [3:0] to;
        logic [3:0] te;
    } row_t;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pat_odd, pat_even, out_odd, out_even, jitter_2ns, jitter_unstable;
    logic signed [OFFSET_W-1:0] offset_fine;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int rx_eo, rx_ee, eo, ee, np;
    row_t rows [8] = '{
        '{8'h00, 4'h0, 32'h0, 4'h0, 4'h0},
        '{8'h06, 4'h0, 32'h0, 4'h1, 4'h3},
        '{8'h1E, 4'h0, 32'h0, 4'h2, 4'h0},
        '{8'h86, 4'h0, 32'h0, 4'h0, 4'h1},
        '{8'h06, 4'h4, 32'h0, 4'h1, 4'h0},
        '{8'h01, 4'h0, 32'h0000_2710, 4'h1, 4'h0},
        '{8'h81, 4'h1, 32'hFFFF_D8F0, 4'h0, 4'h0},
        '{8'h07, 4'h0, 32'h0000_0000, 4'h3, 4'h0}
    };

    pair_combiner #(.DEPTH(DELAY_DEPTH)) i_dut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pat_odd(pat_odd), .pat_even(pat_even), .out_odd(out_odd),
        .out_even(out_even), .offset_fine(offset_fine), .jitter_2ns(jitter_2ns),
        .jitter_unstable(jitter_unstable)
    );
    pattern_receiver i_rx (
        .clk(clk), .rst_b(rst_b), .out_odd(out_odd), .out_even(out_even),
        .edges_odd(rx_eo), .edges_even(rx_ee)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic podd(int c);
        return c[1] ^ c[3] ^ c[4];
    endfunction
    function automatic logic peven(int c);
        return c[0] ^ c[2] ^ c[5];
    endfunction

    // pattern source, one level per cycle
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pat_odd <= podd(cyc + 1);
        pat_even <= peven(cyc + 1);
    end

    function automatic logic [1:0] exp_out(row_t r, int m);
        logic po, pe, co, ce;
        po = podd(m - 3 - int'(r.to));
        pe = peven(m - 3 - int'(r.te));
        co = (r.ctrl[BIT_ADD_ODD] && !r.map[BIT_SINGLE_MOD]) ? po ^ pe : po;
        ce = (r.ctrl[BIT_ADD_EVEN] && !r.map[BIT_SINGLE_MOD]) ? pe & po : pe;
        co = co ^ r.ctrl[BIT_INV_ODD];
        ce = r.ctrl[BIT_OFFSET_EN] ? !po : ce ^ r.ctrl[BIT_INV_EVEN];
        return {co, ce};
    endfunction

    task automatic wrap_up;
        $display("mismatches %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            error_cnt++;
            $display("[ERR] %0t bus timeout", $time);
            wrap_up();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        check({31'h0, err}, {31'h0, e}, "write response");
    endtask

    task automatic get(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e, "read data");
    endtask

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            put(OFS_PAIR_CTRL, 32'h0, 1'b0);
            put(OFS_MAP, 32'(rows[i].map), 1'b0);
            put(OFS_OFFSET, rows[i].ofs, 1'b0);
            put(OFS_DELAY_ODD, 32'(rows[i].to), 1'b0);
            put(OFS_DELAY_EVEN, 32'(rows[i].te), 1'b0);
            put(OFS_PAIR_CTRL, 32'(rows[i].ctrl), 1'b0);
            repeat (20) @(negedge clk);
            eo = rx_eo;
            ee = rx_ee;
            for (int k = 0; k < 16; k++) begin
                @(negedge clk);
                check({30'h0, out_odd, out_even}, {30'h0, exp_out(rows[i], cyc)}, "outputs");
            end
            check(32'(offset_fine), rows[i].ctrl[0] ? rows[i].ofs : 32'h0, "fine offset");
            if (rows[i].ctrl[BIT_OFFSET_EN] && !rows[i].ctrl[BIT_ADD_ODD])
                check(32'(rx_eo - eo), 32'(rx_ee - ee), "edge counts");
        end
        // refused settings
        put(OFS_PAIR_CTRL, 32'h0, 1'b0);
        put(OFS_MAP, 32'h0, 1'b0);
        put(OFS_STATUS, 32'h7, 1'b0);
        put(OFS_OFFSET, 32'h0000_271A, 1'b1);
        put(OFS_OFFSET, 32'hFFFF_D8E6, 1'b1);
        put(OFS_OFFSET, 32'h0000_000E, 1'b1);
        get(OFS_STATUS, 32'h1);
        put(OFS_STATUS, 32'h7, 1'b0);
        get(OFS_STATUS, 32'h0);
        put(OFS_PAIR_CTRL, 32'h40, 1'b0);
        put(OFS_OFFSET, 32'h0000_000E, 1'b0);
        apb(1'b0, OFS_OFFSET, 32'h0);
        check({16'h0, rd[15:0]}, 32'h0000_000E, "offset value");
        put(OFS_MAP, 32'h4, 1'b0);
        put(OFS_PAIR_CTRL, 32'h41, 1'b1);
        put(OFS_MAP, 32'h2, 1'b0);
        put(OFS_PAIR_CTRL, 32'h41, 1'b1);
        get(OFS_STATUS, 32'h2);
        put(OFS_STATUS, 32'h7, 1'b0);
        put(OFS_MAP, 32'h0, 1'b0);
        put(OFS_PAIR_CTRL, 32'h41, 1'b0);
        put(OFS_MAP, 32'h2, 1'b1);
        put(OFS_MAP, 32'h1, 1'b0);
        get(OFS_MAP, 32'h1);
        // jitter span
        put(OFS_PAIR_CTRL, 32'h0, 1'b0);
        put(OFS_MAP, 32'h8, 1'b0);
        put(OFS_PAIR_CTRL, 32'h20, 1'b0);
        np = 0;
        repeat (5) begin
            @(negedge clk);
            if (jitter_unstable === 1'b1) np++;
        end
        check(32'(np), 32'(JITTER_SETTLE_CYC), "unstable pulse");
        check({31'h0, jitter_2ns}, 32'h1, "span wide");
        put(OFS_PAIR_CTRL, 32'h0, 1'b0);
        @(negedge clk);
        check({31'h0, jitter_2ns}, 32'h0, "span narrow");
        put(OFS_MAP, 32'h0, 1'b0);
        put(OFS_PAIR_CTRL, 32'h20, 1'b0);
        @(negedge clk);
        check({31'h0, jitter_2ns}, 32'h0, "span ignored");
        apb(1'b0, 8'h20, 32'h0);
        check(rd, UNMAPPED_WORD, "unmapped read");
        check({31'h0, err}, 32'h0, "unmapped response");
        // reset in mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        @(negedge clk);
        check({out_odd, out_even, jitter_2ns, jitter_unstable, 16'(offset_fine)}, 20'h0, "reset");
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 6; a++)
            get(8'(4 * a), RESET_WORD);
        wrap_up();
    end
endmodule
